// file: src/wake_on_lan_indication.sv
// wake-on-lan receive filter configuration, status and indication
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module wake_on_lan_indication (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [wol_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [wol_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [wol_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [wol_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // receive filter verdict, one pulse per frame
    input wire logic frame_done,
    input wire logic frame_sfd_err,
    input wire logic frame_crc_bad,
    input wire logic frame_is_wake,
    input wire logic frame_pw_ok,
    // strap and other interrupt source
    input wire logic wake_irq_strap,
    input wire logic data_pol_irq,
    // indications
    output logic wake_ind,
    output logic int_bit1,
    output logic irq
);

    // ********************************************
    // state
    // ********************************************
    typedef struct packed {
        logic [wol_pkg::REG_W-1:0] cfg;
        logic [wol_pkg::REG_W-1:0] stat;
        logic [wol_pkg::IRQ_N-1:0] irq_st;
        logic [wol_pkg::IRQ_N-1:0] irq_en;
        logic level;
        logic strap_done;
        logic int_out;
        logic aw_got;
        logic [wol_pkg::ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [wol_pkg::REG_W-1:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [wol_pkg::DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } wol_s;

    wol_s r, nxt;
    logic pulse_fire;
    logic pulse_out;

    // ********************************************
    // pulse generator
    // ********************************************
    wake_pulse_gen u_wake_pulse_gen (
        .aclk(aclk),
        .aresetn(aresetn),
        .fire(pulse_fire),
        .width_sel(r.cfg[wol_pkg::CFG_PSEL_HI:wol_pkg::CFG_PSEL_LO]),
        .pulse(pulse_out)
    );

    // ********************************************
    // frame events
    // ********************************************
    logic ev;
    logic gated;
    logic pw_fail;
    logic ev_sfd;
    logic ev_crc;
    logic ev_hack;
    logic ev_wake;

    always_comb begin
        ev = frame_done && r.cfg[wol_pkg::CFG_WOL_EN];
        gated = r.cfg[wol_pkg::CFG_CRC_GATE] && frame_crc_bad;
        pw_fail = r.cfg[wol_pkg::CFG_PW_EN] && !frame_pw_ok;
        ev_sfd = ev && frame_sfd_err;
        ev_crc = ev && frame_crc_bad;
        ev_hack = ev && frame_is_wake && !gated && pw_fail;
        ev_wake = ev && frame_is_wake && !gated && !pw_fail;
        pulse_fire = ev_wake && !r.cfg[wol_pkg::CFG_IND_SEL];
    end

    // ********************************************
    // read decode
    // ********************************************
    function automatic logic [wol_pkg::DATA_W:0] read_word(
        input logic [wol_pkg::ADDR_W-1:0] a, input wol_s s);
        logic [wol_pkg::DATA_W:0] v;
        v = '0;
        case (a)
            wol_pkg::ADDR_CFG: v[wol_pkg::REG_W-1:0] = s.cfg;
            wol_pkg::ADDR_STAT: v[wol_pkg::REG_W-1:0] = s.stat;
            wol_pkg::ADDR_IRQ_ST: v[wol_pkg::IRQ_N-1:0] = s.irq_st;
            wol_pkg::ADDR_IRQ_EN: v[wol_pkg::IRQ_N-1:0] = s.irq_en;
            wol_pkg::ADDR_IRQ_CLR: v = '0;
            default: v[wol_pkg::DATA_W] = 1'b1;
        endcase
        return v;
    endfunction : read_word

    // ********************************************
    // next state
    // ********************************************
    logic [wol_pkg::REG_W-1:0] wm;
    logic [wol_pkg::REG_W-1:0] newcfg;
    logic [wol_pkg::DATA_W:0] rd;
    logic wr_go;
    logic [wol_pkg::IRQ_N-1:0] irq_clr;
    logic lvl_clr;

    always_comb begin
        nxt = r;
        wm = {{8{r.w_strb[1]}}, {8{r.w_strb[0]}}};
        newcfg = r.cfg;
        rd = '0;
        irq_clr = '0;
        lvl_clr = 1'b0;
        wr_go = r.aw_got && r.w_got && !r.bvalid;

        // strap is sampled once, on the first clock after release
        if (!r.strap_done) begin
            nxt.strap_done = 1'b1;
            nxt.cfg[wol_pkg::CFG_WIRQ_EN] = wake_irq_strap;
        end

        // write channels are taken independently, in either order
        if (awvalid && awready) begin
            nxt.aw_got = 1'b1;
            nxt.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            nxt.w_got = 1'b1;
            nxt.w_data = wdata[wol_pkg::REG_W-1:0];
            nxt.w_strb = wstrb[1:0];
        end

        if (wr_go) begin
            nxt.aw_got = 1'b0;
            nxt.w_got = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = wol_pkg::RESP_OKAY;
            case (r.aw_addr)
                wol_pkg::ADDR_CFG: begin
                    newcfg = (r.cfg & ~(wol_pkg::CFG_WMASK & wm))
                        | (r.w_data & wol_pkg::CFG_WMASK & wm);
                    nxt.cfg = newcfg;
                    lvl_clr = r.w_data[wol_pkg::CFG_LVL_CLR]
                        && wm[wol_pkg::CFG_LVL_CLR];
                    // enabling detection steers the source to wake
                    if (newcfg[wol_pkg::CFG_WOL_EN]
                        && !r.cfg[wol_pkg::CFG_WOL_EN]) begin
                        nxt.stat[wol_pkg::ST_SRC] = 1'b1;
                    end
                end
                wol_pkg::ADDR_STAT: begin
                    nxt.stat = (r.stat & ~(wol_pkg::STAT_WMASK & wm))
                        | (r.w_data & wol_pkg::STAT_WMASK & wm);
                    nxt.stat = nxt.stat
                        & ~(r.w_data & wol_pkg::STAT_W1C & wm);
                end
                wol_pkg::ADDR_IRQ_CLR: begin
                    if (r.w_strb[0]) begin
                        irq_clr = r.w_data[wol_pkg::IRQ_N-1:0];
                    end
                end
                wol_pkg::ADDR_IRQ_EN: begin
                    if (r.w_strb[0]) begin
                        nxt.irq_en = r.w_data[wol_pkg::IRQ_N-1:0];
                    end
                end
                wol_pkg::ADDR_IRQ_ST: begin
                    nxt.bresp = wol_pkg::RESP_OKAY;
                end
                default: nxt.bresp = wol_pkg::RESP_SLVERR;
            endcase
        end
        if (r.bvalid && bready) begin
            nxt.bvalid = 1'b0;
        end

        // reads
        if (arvalid && arready) begin
            rd = read_word(araddr, r);
            nxt.rvalid = 1'b1;
            nxt.rdata = rd[wol_pkg::DATA_W-1:0];
            nxt.rresp = rd[wol_pkg::DATA_W] ? wol_pkg::RESP_SLVERR
                : wol_pkg::RESP_OKAY;
        end else if (r.rvalid && rready) begin
            nxt.rvalid = 1'b0;
        end

        // hardware sets win over software clears
        nxt.irq_st = r.irq_st & ~irq_clr;
        if (ev_sfd) begin
            nxt.stat[wol_pkg::ST_SFD] = 1'b1;
            nxt.irq_st[wol_pkg::IRQ_SFD] = 1'b1;
        end
        if (ev_crc) begin
            nxt.stat[wol_pkg::ST_CRC] = 1'b1;
            nxt.irq_st[wol_pkg::IRQ_CRC] = 1'b1;
        end
        if (ev_hack) begin
            nxt.stat[wol_pkg::ST_HACK] = 1'b1;
            nxt.irq_st[wol_pkg::IRQ_PW] = 1'b1;
        end
        if (ev_wake) begin
            nxt.stat[wol_pkg::ST_WAKE] = 1'b1;
            nxt.irq_st[wol_pkg::IRQ_WAKE] = 1'b1;
        end

        // level mode: a wake in the clearing cycle keeps the level
        if (lvl_clr) begin
            nxt.level = 1'b0;
        end
        if (ev_wake && r.cfg[wol_pkg::CFG_IND_SEL]) begin
            nxt.level = 1'b1;
        end

        // shared interrupt line, wake side held by the sticky status
        nxt.int_out = r.stat[wol_pkg::ST_SRC]
            ? (r.stat[wol_pkg::ST_WAKE] && r.cfg[wol_pkg::CFG_WIRQ_EN])
            : data_pol_irq;
    end

    // ********************************************
    // registers
    // ********************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r.cfg <= wol_pkg::CFG_RST;
            r.stat <= wol_pkg::STAT_RST;
            r.irq_st <= wol_pkg::IRQ_RST;
            r.irq_en <= wol_pkg::IRQ_RST;
            r.level <= 1'b0;
            r.strap_done <= 1'b0;
            r.int_out <= 1'b0;
            r.aw_got <= 1'b0;
            r.aw_addr <= '0;
            r.w_got <= 1'b0;
            r.w_data <= '0;
            r.w_strb <= '0;
            r.bvalid <= 1'b0;
            r.bresp <= wol_pkg::RESP_OKAY;
            r.rvalid <= 1'b0;
            r.rdata <= '0;
            r.rresp <= wol_pkg::RESP_OKAY;
        end else begin
            r <= nxt;
        end
    end

    // ********************************************
    // outputs
    // ********************************************
    assign awready = !r.aw_got && !r.bvalid;
    assign wready = !r.w_got && !r.bvalid;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign arready = !r.rvalid;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    // mode switch mid-indication simply shows the newly chosen source
    assign wake_ind = r.cfg[wol_pkg::CFG_IND_SEL] ? r.level : pulse_out;
    assign int_bit1 = r.int_out;
    assign irq = |(r.irq_st & r.irq_en);

endmodule : wake_on_lan_indication

// file: src/wol_pkg.sv
// constants and types shared by the wake-on-lan indication block
package wol_pkg;

    // ********************************************
    // bus geometry and register map
    // ********************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    // register indexes; byte address is four times the index
    localparam logic [11:0] IDX_CFG = 12'h4a0;
    localparam logic [11:0] IDX_STAT = 12'h4a1;
    localparam logic [11:0] IDX_IRQ_ST = 12'h4b0;
    localparam logic [11:0] IDX_IRQ_CLR = 12'h4b1;
    localparam logic [11:0] IDX_IRQ_EN = 12'h4b2;
    localparam logic [15:0] ADDR_CFG = {2'h0, IDX_CFG, 2'h0};
    localparam logic [15:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
    localparam logic [15:0] ADDR_IRQ_ST = {2'h0, IDX_IRQ_ST, 2'h0};
    localparam logic [15:0] ADDR_IRQ_CLR = {2'h0, IDX_IRQ_CLR, 2'h0};
    localparam logic [15:0] ADDR_IRQ_EN = {2'h0, IDX_IRQ_EN, 2'h0};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************
    // wake_filter_config fields
    // ********************************************
    localparam logic [15:0] CFG_RST = 16'h1081;
    localparam logic [15:0] CFG_WMASK = 16'h17e1;
    localparam int CFG_CRC_GATE = 12;
    localparam int CFG_LVL_CLR = 11;
    localparam int CFG_PSEL_HI = 10;
    localparam int CFG_PSEL_LO = 9;
    localparam int CFG_IND_SEL = 8;
    localparam int CFG_WOL_EN = 7;
    localparam int CFG_PW_EN = 5;
    localparam int CFG_WIRQ_EN = 0;

    // ********************************************
    // wake_filter_status fields
    // ********************************************
    localparam logic [15:0] STAT_RST = 16'h1000;
    localparam logic [15:0] STAT_WMASK = 16'h1000;
    localparam logic [15:0] STAT_W1C = 16'h00e1;
    localparam int ST_SRC = 12;
    localparam int ST_SFD = 7;
    localparam int ST_CRC = 6;
    localparam int ST_HACK = 5;
    localparam int ST_WAKE = 0;

    // ********************************************
    // interrupt bits
    // ********************************************
    localparam int IRQ_N = 4;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_SFD = 1;
    localparam int IRQ_CRC = 2;
    localparam int IRQ_PW = 3;
    localparam logic [IRQ_N-1:0] IRQ_RST = 4'h0;

    // ********************************************
    // wake pulse
    // ********************************************
    localparam int PCNT_W = 7;
    localparam logic [PCNT_W-1:0] PULSE_BASE = 7'h08;
    localparam logic [PCNT_W-1:0] PCNT_ONE = 7'h01;
    localparam logic [PCNT_W-1:0] PCNT_ZERO = 7'h00;

    typedef enum logic [1:0] {
        P_IDLE = 2'b01,
        P_BUSY = 2'b10
    } pulse_state_e;

endpackage : wol_pkg

// file: src/wake_pulse_gen.sv
// wake pulse generator: fixed-length pulse of 8, 16, 32 or 64 cycles
`timescale 1ns/1ps
module wake_pulse_gen (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // trigger
    input wire logic fire,
    input wire logic [1:0] width_sel,
    // pulse out
    output logic pulse
);

    typedef struct packed {
        wol_pkg::pulse_state_e state;
        logic [wol_pkg::PCNT_W-1:0] cnt;
        logic pulse;
    } pulse_s;

    pulse_s r, nxt;

    always_comb begin
        nxt = r;
        case (r.state)
            wol_pkg::P_IDLE: begin
                if (fire) begin
                    // length is base shifted by the select field
                    nxt.cnt = wol_pkg::PCNT_W'(wol_pkg::PULSE_BASE << width_sel)
                        - wol_pkg::PCNT_ONE;
                    nxt.pulse = 1'b1;
                    nxt.state = wol_pkg::P_BUSY;
                end
            end
            wol_pkg::P_BUSY: begin
                // a new trigger during a pulse is absorbed into it
                if (r.cnt == wol_pkg::PCNT_ZERO) begin
                    nxt.pulse = 1'b0;
                    nxt.state = wol_pkg::P_IDLE;
                end else begin
                    nxt.cnt = r.cnt - wol_pkg::PCNT_ONE;
                end
            end
            default: begin
                nxt.state = wol_pkg::P_IDLE;
                nxt.pulse = 1'b0;
                nxt.cnt = wol_pkg::PCNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r.state <= wol_pkg::P_IDLE;
            r.cnt <= wol_pkg::PCNT_ZERO;
            r.pulse <= 1'b0;
        end else begin
            r <= nxt;
        end
    end

    assign pulse = r.pulse;

endmodule : wake_pulse_gen

// file: dv/wake_on_lan_indication_checker.sv
// port assertions for the wake-on-lan indication block
`timescale 1ns/1ps
module wake_on_lan_indication_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // frame input and indications
    input wire logic frame_done,
    input wire logic wake_ind,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ********
    // indication
    // ********
    a_pulse_min_len: assert property (
        $rose(wake_ind) |-> wake_ind [*8])
        else $error("wake indication shorter than eight cycles");
    a_wake_has_frame: assert property (
        $rose(wake_ind) |-> $past(frame_done))
        else $error("wake indication without a frame");
    // an enable write may expose a flag that is already set
    a_irq_has_cause: assert property (
        $rose(irq) |-> $past(frame_done) || bvalid)
        else $error("interrupt raised without event or write");

    // ********
    // register bus
    // ********
    a_read_refused: assert property (
        rvalid |-> !arready)
        else $error("read address taken while data pending");
    a_write_refused: assert property (
        bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (
        arvalid && arready |=> rvalid)
        else $error("read data late");
    a_write_answer: assert property (
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_resp_release: assert property (
        bvalid && bready |=> !bvalid)
        else $error("write response held after acceptance");

    c_wake: cover property ($rose(wake_ind));
    c_irq: cover property ($rose(irq));
    c_read: cover property (arvalid && arready);
endmodule : wake_on_lan_indication_checker

// file: dv/frame_source.sv
// link partner model: one filter verdict per received frame
`timescale 1ns/1ps
module frame_source (
    // clock
    input wire logic aclk,
    // verdict of the receive filter
    output logic frame_done,
    output logic frame_sfd_err,
    output logic frame_crc_bad,
    output logic frame_is_wake,
    output logic frame_pw_ok
);
    initial begin
        frame_done = 1'b0;
        {frame_sfd_err, frame_crc_bad, frame_is_wake, frame_pw_ok} = 4'ha;
    end

    // q is {sfd error, bad crc, wake frame, password ok}
    task automatic send(input logic [3:0] q);
        @(posedge aclk);
        frame_done <= 1'b1;
        {frame_sfd_err, frame_crc_bad, frame_is_wake, frame_pw_ok} <= q;
        @(posedge aclk);
        frame_done <= 1'b0;
        // qualifiers mean nothing between frames: never leave them valid
        {frame_sfd_err, frame_crc_bad, frame_is_wake, frame_pw_ok} <= ~q;
    endtask : send
endmodule : frame_source

// file: dv/test_wake_on_lan_indication.sv
// self-checking bench for the wake-on-lan indication block
`timescale 1ns/1ps
module test_wake_on_lan_indication;
    // ********
    // signals
    // ********
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic data_pol_irq = 1'b0;
    logic [15:0] awaddr = 16'h0;
    logic [15:0] araddr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [2:0] awprot = 3'h0;
    logic [2:0] arprot = 3'h0;
    logic wake_irq_strap = 1'b1;
    logic awready, wready, bvalid, arready, rvalid;
    logic wake_ind, int_bit1, irq, frame_done;
    logic frame_sfd_err, frame_crc_bad, frame_is_wake, frame_pw_ok;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int fails = 0;
    int checks = 0;
    int n;

    always #25 aclk = ~aclk;

    frame_source u_frame_source (
        .aclk(aclk), .frame_done(frame_done), .frame_sfd_err(frame_sfd_err),
        .frame_crc_bad(frame_crc_bad), .frame_is_wake(frame_is_wake),
        .frame_pw_ok(frame_pw_ok)
    );

    wake_on_lan_indication u_wake_on_lan_indication (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .frame_done(frame_done), .frame_sfd_err(frame_sfd_err),
        .frame_crc_bad(frame_crc_bad), .frame_is_wake(frame_is_wake),
        .frame_pw_ok(frame_pw_ok), .wake_irq_strap(wake_irq_strap),
        .data_pol_irq(data_pol_irq), .wake_ind(wake_ind),
        .int_bit1(int_bit1), .irq(irq)
    );

    // ********
    // helpers
    // ********
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d,
            input logic [1:0] er = wol_pkg::RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask : wr

    task automatic rc(input logic [15:0] a, input logic [31:0] e,
            input logic [1:0] er = wol_pkg::RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk({rresp, rdata}, {er, e});
    endtask : rc

    // cycles of high wake indication over a fixed window
    task automatic pw(output int c);
        c = 0;
        repeat (100) begin
            @(posedge aclk);
            if (wake_ind === 1'b1) c++;
        end
    endtask : pw

    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    // ********
    // scenarios
    // ********
    task automatic s_reset;
        rc(wol_pkg::ADDR_CFG, 32'h1081);
        rc(wol_pkg::ADDR_STAT, 32'h1000);
        rc(wol_pkg::ADDR_IRQ_ST, 32'h0);
        rc(16'h0010, 32'h0, wol_pkg::RESP_SLVERR);
        wr(16'h0010, 16'hffff, wol_pkg::RESP_SLVERR);
    endtask : s_reset

    task automatic s_pulse;
        for (int s = 0; s < 4; s++) begin
            wr(wol_pkg::ADDR_CFG, 16'h1081 | (16'(s) << 9));
            u_frame_source.send(4'h3);
            pw(n);
            chk(n, 8 << s);
            rc(wol_pkg::ADDR_STAT, 32'h1001);
            wr(wol_pkg::ADDR_STAT, 16'h1001);
        end
    endtask : s_pulse

    task automatic s_level;
        wr(wol_pkg::ADDR_CFG, 16'h1181);
        u_frame_source.send(4'h3);
        pw(n);
        chk(n, 100);
        wr(wol_pkg::ADDR_CFG, 16'h1981);
        pw(n);
        chk(n, 0);
        rc(wol_pkg::ADDR_CFG, 32'h1181);
        wr(wol_pkg::ADDR_STAT, 16'h1001);
    endtask : s_level

    task automatic s_crc;
        wr(wol_pkg::ADDR_CFG, 16'h1081);
        u_frame_source.send(4'h7);
        pw(n);
        chk(n, 0);
        rc(wol_pkg::ADDR_STAT, 32'h1040);
        wr(wol_pkg::ADDR_STAT, 16'h1040);
        wr(wol_pkg::ADDR_CFG, 16'h0081);
        u_frame_source.send(4'h7);
        pw(n);
        chk(n, 8);
        rc(wol_pkg::ADDR_STAT, 32'h1041);
        wr(wol_pkg::ADDR_STAT, 16'h1041);
    endtask : s_crc

    task automatic s_flags;
        wr(wol_pkg::ADDR_CFG, 16'h10a1);
        u_frame_source.send(4'h2);
        u_frame_source.send(4'h8);
        pw(n);
        chk(n, 0);
        rc(wol_pkg::ADDR_STAT, 32'h10a0);
        u_frame_source.send(4'h3);
        pw(n);
        chk(n, 8);
        wr(wol_pkg::ADDR_STAT, 16'h10a1);
        rc(wol_pkg::ADDR_STAT, 32'h1000);
    endtask : s_flags

    task automatic s_enable;
        wr(wol_pkg::ADDR_STAT, 16'h0000);
        data_pol_irq <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(int_bit1, 1'b1);
        data_pol_irq <= 1'b0;
        wr(wol_pkg::ADDR_CFG, 16'h1001);
        u_frame_source.send(4'h3);
        pw(n);
        chk(n, 0);
        rc(wol_pkg::ADDR_STAT, 32'h0);
        wr(wol_pkg::ADDR_CFG, 16'h1081);
        rc(wol_pkg::ADDR_STAT, 32'h1000);
    endtask : s_enable

    task automatic s_irq;
        // earlier scenarios left every interrupt status bit set
        rc(wol_pkg::ADDR_IRQ_ST, 32'hf);
        wr(wol_pkg::ADDR_IRQ_CLR, 16'h000f);
        wr(wol_pkg::ADDR_IRQ_EN, 16'h000f);
        u_frame_source.send(4'h3);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        chk(int_bit1, 1'b1);
        u_frame_source.send(4'h8);
        rc(wol_pkg::ADDR_IRQ_ST, 32'h3);
        wr(wol_pkg::ADDR_IRQ_CLR, 16'h0003);
        rc(wol_pkg::ADDR_IRQ_ST, 32'h0);
        chk(irq, 1'b0);
        wr(wol_pkg::ADDR_IRQ_EN, 16'h0000);
        u_frame_source.send(4'h3);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        rc(wol_pkg::ADDR_IRQ_ST, 32'h1);
        wr(wol_pkg::ADDR_CFG, 16'h1080);
        repeat (2) @(posedge aclk);
        chk(int_bit1, 1'b0);
    endtask : s_irq

    // mid-run reset with the strap low, then a high-byte-only write
    task automatic s_strap;
        wake_irq_strap <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(wol_pkg::ADDR_CFG, 32'h1080);
        rc(wol_pkg::ADDR_IRQ_ST, 32'h0);
        awprot <= 3'h7;
        arprot <= 3'h7;
        wstrb <= 4'h2;
        wr(wol_pkg::ADDR_CFG, 16'h0001);
        rc(wol_pkg::ADDR_CFG, 32'h0080);
        wstrb <= 4'hf;
    endtask : s_strap

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        s_reset();
        s_pulse();
        s_level();
        s_crc();
        s_flags();
        s_enable();
        s_irq();
        s_strap();
        finish_test();
    end

    // the whole run needs well under 200 us
    initial begin
        #1ms;
        fails++;
        finish_test();
    end
endmodule : test_wake_on_lan_indication

bind wake_on_lan_indication wake_on_lan_indication_checker
        u_wake_on_lan_indication_checker (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .frame_done(frame_done), .wake_ind(wake_ind), .irq(irq)
);
